// ---- hdl/phy_link_mode_map.svh ----
`ifndef PHY_LINK_MODE_MAP_SVH
`define PHY_LINK_MODE_MAP_SVH

// Register byte offsets
`define CTRL_OFS          8'h00
`define SLOT_OFS          8'h04
`define STAT_OFS          8'h08

// Control word field positions
`define RX_WDOG_LIM_HI    19
`define RX_WDOG_LIM_LO    16
`define RX_WDOG_EN_BIT    14
`define DRV_DIS_BIT       13
`define SERDES_LB_BIT     11
`define CELL_LEN_HI       10
`define CELL_LEN_LO       4
`define LEN_OVR_BIT       3
`define INT_LB_BIT        2
`define TX_MULTI_BIT      1
`define RX_MULTI_BIT      0

// Reset values
`define CTRL_RST          32'h0000_0344
`define SLOT_RST          32'h0000_0000
`define CELL_LEN_RST      7'h34

// Cell length limits and standard lengths in bytes
`define CELL_LEN_MIN      7'h01
`define CELL_LEN_MAX      7'h40
`define STD_CELL_HEC      7'h35
`define STD_CELL_NOHEC    7'h34

// Slot type codes
`define TYPE_POSPHY       3'h1
`define TYPE_UTOPIA       3'h3
`define TYPE_FRAMER       3'h5

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ---- hdl/phy_link_mode_pkg.sv ----
package phy_link_mode_pkg;

	typedef struct packed {
		logic [3:0] rx_wdog_lim;
		logic       rx_wdog_en;
		logic       drv_dis;
		logic       serdes_lb;
		logic [6:0] cell_len;
		logic       len_ovr;
		logic       int_lb;
		logic       tx_multi;
		logic       rx_multi;
	} mode_ctrl_t;

	typedef struct packed {
		logic [3:0][2:0] rx_type;
		logic [3:0][2:0] tx_type;
	} slot_types_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_beat_t;

	typedef enum logic [1:0] {
		RX_POLL = 2'b01,
		RX_BUSY = 2'b10
	} rx_state_t;

endpackage

// ---- hdl/phy_link_mode_control.sv ----
`timescale 1ns/100ps

`include "phy_link_mode_map.svh"

module phy_link_mode_control (
	input  wire logic                        core_clk,
	input  wire logic                        srst,
	// AXI4-Lite slave
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Core side transmit stream and port choice
	input  wire phy_link_mode_pkg::byte_beat_t tx_beat,
	input  wire logic [1:0]                  tx_port,
	input  wire logic                        tx_serial,
	// Core side receive stream
	output phy_link_mode_pkg::byte_beat_t    rx_beat,
	output logic [1:0]                       rx_port,
	// Cell framing seen by the link engines
	output logic [6:0]                       cell_len,
	output logic                             hec_gen,
	// PHY bus pins
	input  wire logic                        phy_clk,
	input  wire logic                        phy_rx_avail,
	input  wire logic                        phy_rx_dvalid,
	input  wire logic [7:0]                  phy_rx_data,
	output logic [7:0]                       phy_tx_data,
	output logic                             phy_tx_data_oe,
	output logic                             phy_tx_en_n,
	output logic                             phy_tx_en_n_oe,
	output logic [1:0]                       phy_tx_addr,
	output logic [1:0]                       phy_rx_addr,
	output logic                             phy_addr_oe,
	output logic                             phy_rx_en_n,
	output logic                             phy_rx_en_n_oe,
	// Serializer pins
	input  wire logic                        serdes_rx_in,
	output logic                             serdes_tx_out
);
	import phy_link_mode_pkg::*;

	function automatic logic is_utopia(input logic [2:0] t);
		return t == `TYPE_UTOPIA;
	endfunction

	function automatic logic [6:0] clamp_len(input logic [6:0] v);
		if (v < `CELL_LEN_MIN)
			return `CELL_LEN_MIN;
		else if (v > `CELL_LEN_MAX)
			return `CELL_LEN_MAX;
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	mode_ctrl_t  ctrl_ff;
	slot_types_t slot_ff;
	logic [3:0]  wdog_flag_ff;
	logic        aw_got_ff;
	logic        w_got_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        wr_fire;
	logic [31:0] ctrl_word;
	logic [31:0] wr_word;
	logic [3:0]  flag_set;

	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[`RX_WDOG_LIM_HI:`RX_WDOG_LIM_LO] = ctrl_ff.rx_wdog_lim;
		ctrl_word[`RX_WDOG_EN_BIT] = ctrl_ff.rx_wdog_en;
		ctrl_word[`DRV_DIS_BIT] = ctrl_ff.drv_dis;
		ctrl_word[`SERDES_LB_BIT] = ctrl_ff.serdes_lb;
		ctrl_word[`CELL_LEN_HI:`CELL_LEN_LO] = ctrl_ff.cell_len;
		ctrl_word[`LEN_OVR_BIT] = ctrl_ff.len_ovr;
		ctrl_word[`INT_LB_BIT] = ctrl_ff.int_lb;
		ctrl_word[`TX_MULTI_BIT] = ctrl_ff.tx_multi;
		ctrl_word[`RX_MULTI_BIT] = ctrl_ff.rx_multi;
	end

	// Byte lanes merged over the current value so partial writes keep the rest
	always_comb begin
		wr_word = (awaddr_ff == `SLOT_OFS) ? 32'(slot_ff) : ctrl_word;
		for (int i = 0; i < 4; i++) begin
			if (wstrb_ff[i]) begin
				wr_word[i*8 +: 8] = wdata_ff[i*8 +: 8];
			end
		end
	end

	assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			aw_got_ff     <= 1'b0;
			awaddr_ff     <= 8'h00;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_ff     <= 1'b1;
			awaddr_ff     <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_got_ff     <= 1'b0;
		end else if (!aw_got_ff && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			w_got_ff     <= 1'b0;
			wdata_ff     <= 32'h0000_0000;
			wstrb_ff     <= 4'h0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_ff     <= 1'b1;
			wdata_ff     <= s_axi_wdata;
			wstrb_ff     <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wr_fire) begin
			w_got_ff     <= 1'b0;
		end else if (!w_got_ff && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_ff == `CTRL_OFS || awaddr_ff == `SLOT_OFS ||
				awaddr_ff == `STAT_OFS) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_ff.rx_wdog_lim <= 4'h0;
			ctrl_ff.rx_wdog_en  <= 1'b0;
			ctrl_ff.drv_dis     <= 1'b0;
			ctrl_ff.serdes_lb   <= 1'b0;
			ctrl_ff.cell_len    <= `CELL_LEN_RST;
			ctrl_ff.len_ovr     <= 1'b0;
			ctrl_ff.int_lb      <= 1'b1;
			ctrl_ff.tx_multi    <= 1'b0;
			ctrl_ff.rx_multi    <= 1'b0;
		end else if (wr_fire && awaddr_ff == `CTRL_OFS) begin
			ctrl_ff.rx_wdog_lim <= wr_word[`RX_WDOG_LIM_HI:`RX_WDOG_LIM_LO];
			ctrl_ff.rx_wdog_en  <= wr_word[`RX_WDOG_EN_BIT];
			ctrl_ff.drv_dis     <= wr_word[`DRV_DIS_BIT];
			ctrl_ff.serdes_lb   <= wr_word[`SERDES_LB_BIT];
			// Out of range lengths saturate so the engines never see zero
			ctrl_ff.cell_len    <= clamp_len(wr_word[`CELL_LEN_HI:`CELL_LEN_LO]);
			ctrl_ff.len_ovr     <= wr_word[`LEN_OVR_BIT];
			ctrl_ff.int_lb      <= wr_word[`INT_LB_BIT];
			ctrl_ff.tx_multi    <= wr_word[`TX_MULTI_BIT];
			ctrl_ff.rx_multi    <= wr_word[`RX_MULTI_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			slot_ff <= slot_types_t'(`SLOT_RST);
		end else if (wr_fire && awaddr_ff == `SLOT_OFS) begin
			slot_ff <= slot_types_t'(wr_word[23:0]);
		end
	end

	// Timeout flags: write one clears, a new timeout in the same cycle wins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wdog_flag_ff <= 4'h0;
		end else if (wr_fire && awaddr_ff == `STAT_OFS && wstrb_ff[0]) begin
			wdog_flag_ff <= (wdog_flag_ff & ~wdata_ff[3:0]) | flag_set;
		end else begin
			wdog_flag_ff <= wdog_flag_ff | flag_set;
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	rx_state_t rx_state_ff;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `RESP_OKAY;
			unique case (s_axi_araddr)
				`CTRL_OFS: s_axi_rdata <= ctrl_word;
				`SLOT_OFS: s_axi_rdata <= {8'h00, slot_ff};
				`STAT_OFS: s_axi_rdata <= {21'h0, rx_port, rx_state_ff == RX_BUSY,
					4'h0, wdog_flag_ff};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [11:0] pin_s1_ff;
	logic [11:0] pin_s2_ff;
	logic        phy_clk_d_ff;
	logic        link_edge;
	logic        avail_s;
	logic        dvalid_s;
	logic [7:0]  data_s;
	logic        serdes_s;

	always_ff @(posedge core_clk) begin
		pin_s1_ff <= {phy_clk, phy_rx_avail, phy_rx_dvalid, phy_rx_data, serdes_rx_in};
		pin_s2_ff <= pin_s1_ff;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			phy_clk_d_ff <= 1'b0;
		end else begin
			phy_clk_d_ff <= pin_s2_ff[11];
		end
	end

	assign link_edge = pin_s2_ff[11] && !phy_clk_d_ff;
	assign avail_s   = pin_s2_ff[10];
	assign dvalid_s  = pin_s2_ff[9];
	assign data_s    = pin_s2_ff[8:1];
	assign serdes_s  = pin_s2_ff[0];

	// ----------------------------------------------------------------
	// Receive link engine and its watchdog
	// ----------------------------------------------------------------
	logic [3:0] wdog_cnt_ff;
	logic [2:0] rx_type_now;
	logic [2:0] tx_type_now;
	logic       wdog_live;
	logic       wdog_hit;

	assign rx_type_now = ctrl_ff.rx_multi ? slot_ff.rx_type[rx_port] : slot_ff.rx_type[0];
	assign tx_type_now = ctrl_ff.tx_multi ? slot_ff.tx_type[tx_port] : slot_ff.tx_type[0];
	assign wdog_live   = ctrl_ff.rx_wdog_en && ctrl_ff.rx_multi && is_utopia(rx_type_now);
	assign wdog_hit    = wdog_live && rx_state_ff == RX_BUSY && link_edge && !dvalid_s &&
		wdog_cnt_ff == ctrl_ff.rx_wdog_lim;

	always_ff @(posedge core_clk) begin
		if (srst || !wdog_live || rx_state_ff != RX_BUSY) begin
			wdog_cnt_ff <= 4'h0;
		end else if (link_edge) begin
			wdog_cnt_ff <= dvalid_s ? 4'h0 : wdog_cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rx_state_ff <= RX_POLL;
			rx_port     <= 2'h0;
		end else if (!ctrl_ff.rx_multi) begin
			rx_port     <= 2'h0;
			rx_state_ff <= RX_POLL;
		end else if (link_edge) begin
			unique case (rx_state_ff)
				RX_POLL: begin
					if (avail_s) begin
						rx_state_ff <= RX_BUSY;
					end else begin
						rx_port <= rx_port + 2'h1;
					end
				end
				RX_BUSY: begin
					if (wdog_hit || !avail_s) begin
						rx_state_ff <= RX_POLL;
						rx_port     <= rx_port + 2'h1;
					end
				end
			endcase
		end
	end

	assign flag_set = wdog_hit ? (4'h1 << rx_port) : 4'h0;

	// Loopback hands transmit beats straight to the receive stream
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rx_beat <= '0;
		end else if (ctrl_ff.int_lb) begin
			rx_beat <= tx_beat;
		end else begin
			rx_beat.valid <= link_edge && dvalid_s;
			rx_beat.data  <= data_s;
		end
	end

	// ----------------------------------------------------------------
	// Cell framing
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cell_len <= `STD_CELL_HEC;
			hec_gen  <= 1'b1;
		end else if (ctrl_ff.len_ovr && is_utopia(tx_type_now)) begin
			cell_len <= ctrl_ff.cell_len;
			hec_gen  <= 1'b0;
		end else begin
			cell_len <= `STD_CELL_HEC;
			hec_gen  <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// PHY bus drivers
	// ----------------------------------------------------------------
	logic drv_on;

	// Internal loopback also silences the pins so a live PHY sees nothing
	assign drv_on = !ctrl_ff.drv_dis && !ctrl_ff.int_lb;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			phy_tx_data_oe <= 1'b0;
			phy_tx_en_n_oe <= 1'b0;
			phy_addr_oe    <= 1'b0;
			phy_rx_en_n_oe <= 1'b0;
		end else begin
			phy_tx_data_oe <= drv_on;
			phy_tx_en_n_oe <= drv_on;
			phy_addr_oe    <= drv_on;
			phy_rx_en_n_oe <= drv_on;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			phy_tx_data <= 8'h00;
			phy_tx_en_n <= 1'b1;
			phy_tx_addr <= 2'h0;
			phy_rx_addr <= 2'h0;
			phy_rx_en_n <= 1'b1;
		end else begin
			phy_tx_data <= tx_beat.data;
			phy_tx_en_n <= !(tx_beat.valid && !ctrl_ff.int_lb);
			phy_tx_addr <= ctrl_ff.tx_multi ? tx_port : 2'h0;
			phy_rx_addr <= rx_port;
			phy_rx_en_n <= !(rx_state_ff == RX_BUSY || !ctrl_ff.rx_multi) || ctrl_ff.int_lb;
		end
	end

	// ----------------------------------------------------------------
	// Serializer loopback
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			serdes_tx_out <= 1'b0;
		end else begin
			serdes_tx_out <= ctrl_ff.serdes_lb ? serdes_s : tx_serial;
		end
	end

endmodule

// ---- verif/phy_link_mode_chk.sv ----
`timescale 1ns/100ps
module phy_link_mode_chk (
	input wire logic                          core_clk,
	input wire logic                          srst,
	input wire logic                          s_axi_awvalid,
	input wire logic                          s_axi_awready,
	input wire logic                          s_axi_wvalid,
	input wire logic                          s_axi_wready,
	input wire logic [1:0]                    s_axi_bresp,
	input wire logic                          s_axi_bvalid,
	input wire logic                          s_axi_bready,
	input wire logic [7:0]                    s_axi_araddr,
	input wire logic                          s_axi_arvalid,
	input wire logic                          s_axi_arready,
	input wire logic [31:0]                   s_axi_rdata,
	input wire logic [1:0]                    s_axi_rresp,
	input wire logic                          s_axi_rvalid,
	input wire logic                          s_axi_rready,
	input wire phy_link_mode_pkg::byte_beat_t rx_beat,
	input wire logic [6:0]                    cell_len,
	input wire logic                          hec_gen,
	input wire logic                          phy_tx_data_oe,
	input wire logic                          phy_tx_en_n_oe,
	input wire logic                          phy_addr_oe,
	input wire logic                          phy_rx_en_n_oe
);
	import phy_link_mode_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	chk_oe_all_same: assert property (phy_tx_data_oe == phy_addr_oe && phy_tx_data_oe ==
		phy_tx_en_n_oe && phy_tx_data_oe == phy_rx_en_n_oe) else $error("enables differ");
	chk_len_in_range: assert property (cell_len >= 7'h01 && cell_len <= 7'h40)
		else $error("cell length out of range");
	chk_hec_std_len: assert property (hec_gen |-> cell_len == 7'h35)
		else $error("header check with programmed length");
	chk_reset_state: assert property ($fell(srst) |-> !phy_tx_data_oe && hec_gen &&
		cell_len == 7'h35 && s_axi_awready && !s_axi_bvalid) else $error("bad reset state");
	// Link edges are ten core cycles apart, so only loopback may give adjacent beats
	chk_link_beat_gap: assert property (rx_beat.valid && phy_tx_data_oe |=> !rx_beat.valid)
		else $error("adjacent beats off loopback");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
		$stable(s_axi_bresp)) else $error("write response dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata)) else $error("read data dropped");
	chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
		!s_axi_arready) else $error("read not answered");
	chk_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0b
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
	chk_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	cover property (rx_beat.valid && !phy_tx_data_oe);
	cover property (!hec_gen);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind phy_link_mode_control phy_link_mode_chk chk (.*);

// ---- verif/phy_side_model.sv ----
`timescale 1ns/100ps
module phy_side_model (
	input  wire logic       run,
	input  wire logic [3:0] has_data,
	input  wire logic       stall,
	input  wire logic [1:0] rx_addr,
	output logic            link_clk,
	output logic            avail,
	output logic            dvalid,
	output logic [7:0]      data,
	output logic            serial
);
	// Link clock stands still while no traffic is wanted
	initial begin
		link_clk = 1'h0;
		data = 8'h00;
		dvalid = 1'h0;
		serial = 1'h0;
		#3;
		forever begin
			#40 link_clk = run ? ~link_clk : 1'h0;
		end
	end
	assign avail = has_data[rx_addr];
	// A stall models a PHY that began a transfer and then ran dry
	// Valid and data move together so a sampled valid never meets stale data
	always @(negedge link_clk) begin
		dvalid <= avail && !stall;
		data <= (avail && !stall) ? {6'h2a, rx_addr} : ~data;
		serial <= ~serial;
	end
endmodule

// ---- verif/tb_phy_link_mode_control.sv ----
`timescale 1ns/100ps
`include "phy_link_mode_map.svh"
module tb_phy_link_mode_control;
	import phy_link_mode_pkg::*;
	logic        core_clk = 1'h0, srst = 1'h1, tx_serial = 1'h0, run = 1'h0, stall = 1'h0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, phy_rx_data, phy_tx_data, b;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rmask = '1;
	logic [3:0]  s_axi_wstrb = 4'hf, has_data = '0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, tx_port = '0, rx_port, phy_tx_addr, phy_rx_addr;
	logic [1:0]  exp_port = '0;
	logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic        s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, phy_clk, phy_rx_avail;
	logic        phy_rx_dvalid, serdes_rx_in, serdes_tx_out, hec_gen, phy_tx_data_oe;
	logic        phy_tx_en_n, phy_tx_en_n_oe, phy_addr_oe, phy_rx_en_n, phy_rx_en_n_oe;
	logic [6:0]  cell_len, lens[6], exps[6];
	byte_beat_t  tx_beat = '0, rx_beat;
	logic [33:0] bq[$], rq[$], dq[$];
	int          miscompares = 0, total_checks = 0, cyc = 0;
	wire  [3:0]  oes = {phy_tx_data_oe, phy_addr_oe, phy_tx_en_n_oe, phy_rx_en_n_oe};

	always #4 core_clk = ~core_clk;
	phy_link_mode_control dut (.*);
	phy_side_model phy (.run(run), .has_data(has_data), .stall(stall), .rx_addr(phy_rx_addr),
		.link_clk(phy_clk), .avail(phy_rx_avail), .dvalid(phy_rx_dvalid), .data(phy_rx_data),
		.serial(serdes_rx_in));

	task chk(input logic [33:0] got, input logic [33:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task cycles(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		bq.push_back(r);
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		rq.push_back(e & {2'h3, rmask});
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask

	// ----------------------------------------
	// Result watcher
	// ----------------------------------------
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			results();
		end
		if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata & rmask}, rq.pop_front());
		if (rx_beat.valid && dq.size() > 0) chk(rx_beat.data, dq.pop_front());
		else if (rx_beat.valid) chk(rx_beat.data, {6'h2a, exp_port});
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(86));
		lens = '{7'h00, 7'h01, 7'h40, 7'h41, 7'h7f, 7'h00};
		exps = '{7'h01, 7'h01, 7'h40, 7'h40, 7'h40, 7'h00};
		lens[5] = 7'h01 + 7'($urandom % 64);
		exps[5] = lens[5];
		repeat (5) @(posedge core_clk);
		srst <= 1'h0;
		rd(`CTRL_OFS, {`RESP_OKAY, `CTRL_RST});
		@(negedge core_clk);
		chk({oes, hec_gen, cell_len}, {4'h0, 1'h1, `STD_CELL_HEC});
		rd(8'h0c, {`RESP_SLVERR, 32'h0});
		wr(8'h0c, 32'hffff_ffff, `RESP_SLVERR);
		rd(`CTRL_OFS, {`RESP_OKAY, `CTRL_RST});
		$display("test reset done");
		wr(`CTRL_OFS, 32'h0000_2340, `RESP_OKAY);
		cycles(3);
		chk(oes, 4'h0);
		wr(`CTRL_OFS, 32'h0000_0340, `RESP_OKAY);
		cycles(3);
		chk(oes, 4'hf);
		@(posedge core_clk);
		tx_beat <= {1'h1, 8'h5a};
		cycles(1);
		chk({phy_tx_en_n, phy_tx_data, phy_rx_en_n}, {1'h0, 8'h5a, 1'h0});
		tx_beat <= '0;
		cycles(1);
		chk(phy_tx_en_n, 1'h1);
		$display("test drivers done");
		wr(`SLOT_OFS, 32'h0000_0019, `RESP_OKAY);
		tx_port <= 2'h1;
		for (int i = 0; i < 6; i++) begin
			wr(`CTRL_OFS, {21'h0, lens[i], 4'ha}, `RESP_OKAY);
			rd(`CTRL_OFS, {`RESP_OKAY, 21'h0, exps[i], 4'ha});
			cycles(2);
			chk({hec_gen, cell_len, phy_tx_addr}, {1'h0, exps[i], 2'h1});
		end
		tx_port <= 2'h0;
		cycles(3);
		chk({hec_gen, cell_len}, {1'h1, `STD_CELL_HEC});
		tx_port <= 2'h1;
		wr(`CTRL_OFS, 32'h0000_0348, `RESP_OKAY);
		cycles(3);
		chk({hec_gen, cell_len, phy_tx_addr}, {1'h1, `STD_CELL_HEC, 2'h0});
		$display("test cell length done");
		run <= 1'h1;
		repeat (4) begin
			@(posedge core_clk);
			tx_serial <= 1'($urandom);
			cycles(1);
			chk(serdes_tx_out, tx_serial);
		end
		wr(`CTRL_OFS, 32'h0000_0b40, `RESP_OKAY);
		repeat (3) begin
			@(serdes_rx_in);
			cycles(6);
			chk(serdes_tx_out, serdes_rx_in);
		end
		$display("test serializer done");
		wr(`CTRL_OFS, 32'h0000_0344, `RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			b = 8'($urandom);
			tx_beat <= {1'h1, b};
			dq.push_back(b);
		end
		@(posedge core_clk);
		tx_beat <= '0;
		cycles(4);
		chk({oes, 30'(dq.size())}, 34'h0);
		$display("test loopback done");
		wr(`SLOT_OFS, 32'h006d_b6db, `RESP_OKAY);
		wr(`CTRL_OFS, 32'h0003_4341, `RESP_OKAY);
		exp_port <= 2'h2;
		has_data <= 4'h4;
		cycles(200);
		stall <= 1'h1;
		cycles(200);
		has_data <= 4'h0;
		rmask <= 32'h0000_000f;
		cycles(50);
		rd(`STAT_OFS, {`RESP_OKAY, 32'h4});
		wr(`STAT_OFS, 32'h0000_0004, `RESP_OKAY);
		rd(`STAT_OFS, {`RESP_OKAY, 32'h0});
		wr(`CTRL_OFS, 32'h0003_0341, `RESP_OKAY);
		has_data <= 4'h4;
		cycles(200);
		has_data <= 4'h0;
		cycles(50);
		rd(`STAT_OFS, {`RESP_OKAY, 32'h0});
		wr(`CTRL_OFS, 32'h0000_0340, `RESP_OKAY);
		exp_port <= 2'h0;
		stall <= 1'h0;
		has_data <= 4'hf;
		cycles(200);
		chk(rx_port, 2'h0);
		$display("test watchdog done");
		results();
	end
endmodule
